// ### verilog/hwrt_top.sv
// hwrt_top.sv: halt control, wake-up sequencing, reset cause and tick
// assumes: core gives one-cycle instruction pulses, pins are synchronous
// Overview of operation
// [RL1] tick period chosen by tick_control bits 2..0
// [RL2] tick time-out sets tick_irq_flag, bit 6
// [RL3] enabled tick with room calls vector 0CH
// [RL4] tick pulse offered to timer as clock
// [RL5] halt stops system oscillator, slow ones run
// [RL6] halt keeps memory, registers and ports
// [RL7] halt entry clears watchdog when osc-clocked
// [RL8] halt sets powerdown flag, clears timeout flag
// [RL9] halt ends on reset, irq, port, watchdog
// [RL10] watchdog in halt: timeout flag, warm reset
// [RL11] powerdown flag cleared at power-up, watchdog clear
// [RL12] per-bit build option for port wake
// [RL13] port wake resumes at next instruction
// [RL14] irq wake: vector only if enabled, room
// [RL15] flag set before halt cannot wake
// [RL16] wake waits 1024 clocks, irq one more
// [RL17] power-up also waits 1024 clocks
// [RL18] timeout and powerdown flags encode reset cause
// [RL19] chip reset clears counters, disables interrupts
// [RL20] non-warm reset loads tick_control and port
// [RL21] watchdog in run: chip reset, timeout set
// [RL22] irq flag holds until serviced or cleared
// [RL23] save bit selects fast or low power; bit 4 is only stored here, no output uses it
// [RL24] core held while start-up delay runs
`timescale 1ns/100ps
`default_nettype none
module hwrt_top
  import hwrt_pkg::*;
#(
  parameter logic [7:0] PA_WAKE_EN = 8'hff
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_instr,
  input wire logic watchdog_clear_instr,
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_ovf,
  input wire logic wdt_on_osc,
  input wire logic fs_pulse,
  input wire logic stack_full,
  input wire logic [2:0] ext_irq_flags,
  input wire logic [2:0] ext_irq_en,
  input wire logic [7:0] port_a_pin,
  output logic sys_osc_en,
  output logic cpu_hold,
  output logic chip_reset,
  output logic warm_reset,
  output logic watchdog_clear,
  output logic tick_pulse,
  output logic tick_call,
  output logic [11:0] tick_vector,
  output logic resume_next,
  output logic resume_irq,
  output logic [7:0] port_a_reg,
  output logic timeout_flag,
  output logic powerdown_flag
);
  hwrt_state_t st;
  logic [5:0] tc_r;
  logic [6:0] ic0_r;
  logic [7:0] port_a_r;
  logic [7:0] pa_prev_r;
  logic [7:0] pa_fall;
  logic [3:0] entry_mask_r;
  logic [3:0] irq_src;
  logic [3:0] irq_en_vec;
  logic [3:0] wake_vec;
  logic [31:0] rd_nxt;
  logic [31:0] prdata_r;
  logic to_r;
  logic pd_r;
  logic ext_rst;
  logic chip_rst_now;
  logic warm_now;
  logic halt_go;
  logic wake_any;
  logic irq_serve;
  logic sst_start;
  logic sst_busy;
  logic sst_done;
  logic wake_next_r;
  logic wake_irq_r;
  logic resume_next_r;
  logic irq_dly_r;
  logic resume_irq_r;
  logic chip_reset_r;
  logic warm_reset_r;
  logic wdt_clr_r;
  logic tick_call_r;
  logic wr_acc;

  // true when the byte address hits the given word index
  function automatic logic hwrt_idx_hit(input logic [7:0] a, input logic [5:0] idx);
    hwrt_idx_hit = (a == {idx, 2'b00});
  endfunction : hwrt_idx_hit

  function automatic logic hwrt_mapped(input logic [7:0] a);
    hwrt_mapped = hwrt_idx_hit(a, IDX_TICK_CTRL) || hwrt_idx_hit(a, IDX_STATUS) ||
      hwrt_idx_hit(a, IDX_IRQ_CTRL0) || hwrt_idx_hit(a, IDX_PORT_A);
  endfunction : hwrt_mapped

  // event decode; the reset pin outranks a watchdog overflow
  assign ext_rst = !ext_reset_pin_n;
  assign chip_rst_now = ext_rst || (watchdog_ovf && st != HWRT_HALT); // [RL21]
  assign warm_now = watchdog_ovf && st == HWRT_HALT && !ext_rst; // [RL10]
  assign halt_go = st == HWRT_RUN && halt_instr && !ext_rst && !watchdog_ovf;

  // interrupt sources: {timer, time base, external, tick}
  assign irq_src = {ext_irq_flags, ic0_r[IC0_TICK_FLAG_BIT]};
  assign irq_en_vec = {ext_irq_en, ic0_r[IC0_TICK_EN_BIT]};
  assign wake_vec = irq_src & ~entry_mask_r; // [RL15]
  assign irq_serve = ic0_r[IC0_MASTER_BIT] && !stack_full &&
    |(wake_vec & irq_en_vec); // [RL14]

  // per-pin falling edge, each gated by its build option
  for (genvar i = 0; i < 8; i++) begin : g_pa_wake
    assign pa_fall[i] = PA_WAKE_EN[i] && pa_prev_r[i] && !port_a_pin[i]; // [RL12]
  end

  assign wake_any = st == HWRT_HALT && (|wake_vec || |pa_fall) &&
    !ext_rst && !watchdog_ovf; // [RL9]
  assign sst_start = ext_rst || watchdog_ovf || wake_any; // [RL16]

  // sampled pin levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_prev_r <= PA_PREV_RST;
    end else begin
      pa_prev_r <= port_a_pin;
    end
  end

  // pending flags at halt entry are frozen out of the wake decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_mask_r <= 4'h0;
    end else if (halt_go) begin
      entry_mask_r <= irq_src; // [RL15]
    end
  end

  // main sequence; any reset source restarts the start-up delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= HWRT_SST; // [RL17]
    end else if (sst_start) begin
      st <= HWRT_SST; // [RL9]
    end else begin
      unique case (st)
        HWRT_RUN: begin
          if (halt_go) begin
            st <= HWRT_HALT; // [RL5]
          end
        end
        HWRT_HALT: begin
          st <= HWRT_HALT; // [RL6]
        end
        HWRT_SST: begin
          if (sst_done) begin
            st <= HWRT_RUN;
          end
        end
      endcase
    end
  end

  // remember how the wake ended: next instruction or vectoring
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_next_r <= 1'b0;
      wake_irq_r <= 1'b0;
    end else if (ext_rst || watchdog_ovf) begin
      wake_next_r <= 1'b0;
      wake_irq_r <= 1'b0;
    end else if (wake_any) begin
      wake_irq_r <= |wake_vec && irq_serve; // [RL14]
      wake_next_r <= !(|wake_vec && irq_serve); // [RL13]
    end else if (sst_done) begin
      wake_next_r <= 1'b0;
      wake_irq_r <= 1'b0;
    end
  end

  // irq wake costs one cycle beyond the dummy period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_next_r <= 1'b0;
      irq_dly_r <= 1'b0;
      resume_irq_r <= 1'b0;
    end else begin
      resume_next_r <= sst_done && wake_next_r; // [RL13]
      irq_dly_r <= sst_done && wake_irq_r; // [RL16]
      resume_irq_r <= irq_dly_r;
    end
  end

  // reset cause flags; set events take priority over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_r <= 1'b0; // [RL18]
      pd_r <= 1'b0; // [RL11]
    end else if (halt_go) begin
      to_r <= 1'b0; // [RL8]
      pd_r <= 1'b1;
    end else if (st == HWRT_HALT && ext_rst) begin
      to_r <= 1'b0; // [RL18]
    end else if (watchdog_ovf && !ext_rst) begin
      to_r <= 1'b1; // [RL21]
    end else if (watchdog_clear_instr && st == HWRT_RUN) begin
      pd_r <= 1'b0; // [RL11]
    end
  end

  // strobes to the core, watchdog and counters, one cycle each except while the reset pin is held low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_reset_r <= 1'b0;
      warm_reset_r <= 1'b0;
      wdt_clr_r <= 1'b0;
    end else begin
      chip_reset_r <= chip_rst_now; // [RL19]
      warm_reset_r <= warm_now; // [RL10]
      wdt_clr_r <= (halt_go && wdt_on_osc) || chip_rst_now; // [RL7]
    end
  end

  // tick_control; warm reset leaves it alone, chip reset loads bits 4..0 with the save bit, bit 5 only on power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_r <= {1'b0, TC_RST}; // [RL23]
    end else if (chip_rst_now) begin
      tc_r[4:0] <= TC_RST; // [RL20]
    end else if (wr_acc && hwrt_idx_hit(paddr, IDX_TICK_CTRL)) begin
      tc_r <= pwdata[5:0];
    end
  end

  // port latch; a warm reset must not glitch the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_r <= PORT_A_RST;
    end else if (chip_rst_now) begin
      port_a_r <= PORT_A_RST; // [RL20]
    end else if (wr_acc && hwrt_idx_hit(paddr, IDX_PORT_A)) begin
      port_a_r <= pwdata[7:0];
    end
  end

  // irq_control_0; the tick set is applied last so it wins a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ic0_r <= IC0_RST;
    end else if (chip_rst_now) begin
      ic0_r <= IC0_RST; // [RL19]
    end else begin
      if (wr_acc && hwrt_idx_hit(paddr, IDX_IRQ_CTRL0)) begin
        ic0_r <= pwdata[6:0];
      end
      if (tick_call_r) begin
        ic0_r[IC0_TICK_FLAG_BIT] <= 1'b0; // [RL22]
      end
      if (tick_pulse) begin
        ic0_r[IC0_TICK_FLAG_BIT] <= 1'b1; // [RL2]
      end
    end
  end

  // tick call waits out the wake delay and never repeats back to back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_call_r <= 1'b0;
    end else begin
      tick_call_r <= st == HWRT_RUN && !irq_dly_r && !tick_call_r && !chip_rst_now &&
        ic0_r[IC0_MASTER_BIT] && ic0_r[IC0_TICK_EN_BIT] &&
        ic0_r[IC0_TICK_FLAG_BIT] && !stack_full; // [RL3]
    end
  end

  hwrt_tick_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .clr(chip_rst_now),
    .fs_pulse(fs_pulse),
    .sel(tc_r[2:0]),
    .tick_pulse(tick_pulse)
  );

  hwrt_sst u_sst (
    .pclk(pclk),
    .presetn(presetn),
    .start(sst_start),
    .busy(sst_busy),
    .done(sst_done)
  );

  // apb read data is captured in setup so the access phase needs no wait
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (paddr[7:2])
      IDX_TICK_CTRL: rd_nxt[5:0] = tc_r;
      IDX_STATUS: begin
        rd_nxt[ST_TO_BIT] = to_r;
        rd_nxt[ST_PD_BIT] = pd_r;
      end
      IDX_IRQ_CTRL0: rd_nxt[6:0] = ic0_r;
      IDX_PORT_A: rd_nxt[7:0] = port_a_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
    if (paddr[1:0] != 2'b00) begin
      rd_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= rd_nxt;
    end
  end

  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hwrt_mapped(paddr);
  assign prdata = prdata_r;

  // outputs; sys_osc_en and cpu_hold decode the state flip-flop, cpu_hold also irq_dly_r
  assign sys_osc_en = st != HWRT_HALT; // [RL5]
  assign cpu_hold = st != HWRT_RUN || irq_dly_r; // [RL24]
  assign chip_reset = chip_reset_r;
  assign warm_reset = warm_reset_r;
  assign watchdog_clear = wdt_clr_r;
  assign tick_call = tick_call_r;
  assign tick_vector = TICK_VECTOR; // [RL3]
  assign resume_next = resume_next_r;
  assign resume_irq = resume_irq_r;
  assign port_a_reg = port_a_r; // [RL6]
  assign timeout_flag = to_r;
  assign powerdown_flag = pd_r;
  // tick_pulse leaves as the timer's count clock [RL4]

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  flag_set_a: assert property ( // [RL2]
    tick_pulse && !chip_rst_now |=> ic0_r[IC0_TICK_FLAG_BIT])
    else $error("tick did not set flag");
  tick_call_a: assert property ( // [RL3]
    tick_call |-> $past(ic0_r[IC0_MASTER_BIT] && ic0_r[IC0_TICK_EN_BIT] &&
    ic0_r[IC0_TICK_FLAG_BIT] && !stack_full))
    else $error("tick call without cause");
  osc_halt_a: assert property ($fell(sys_osc_en) |-> $past(halt_go)) // [RL5]
    else $error("oscillator stopped without halt entry");
  wdt_clear_a: assert property (halt_go && wdt_on_osc |=> watchdog_clear) // [RL7]
    else $error("watchdog not cleared on halt");
  halt_flags_a: assert property (halt_go |=> pd_r && !to_r && st == HWRT_HALT) // [RL8]
    else $error("halt entry flags wrong");
  warm_reset_a: assert property ( // [RL10]
    warm_now |=> warm_reset && to_r && pd_r && !chip_reset)
    else $error("warm reset wrong");
  pd_clear_a: assert property ( // [RL11]
    watchdog_clear_instr && st == HWRT_RUN && !halt_instr && !watchdog_ovf && !ext_rst
    |=> !pd_r)
    else $error("powerdown flag not cleared");
  stale_irq_a: assert property ( // [RL15]
    st == HWRT_HALT && wake_vec == 4'h0 && pa_fall == 8'h00 && !ext_rst && !watchdog_ovf
    |=> st == HWRT_HALT)
    else $error("woke without fresh event");
  irq_delay_a: assert property ( // [RL16]
    sst_done && wake_irq_r |=> !resume_irq ##1 resume_irq)
    else $error("irq resume not one cycle late");
  hold_a: assert property (sst_busy |-> cpu_hold) // [RL24]
    else $error("core ran during start-up delay");
  reset_load_a: assert property ( // [RL20]
    chip_rst_now |=> tc_r[4:0] == TC_RST && port_a_r == PORT_A_RST && ic0_r == IC0_RST)
    else $error("chip reset values wrong");
endmodule : hwrt_top
`default_nettype wire

// ### verilog/hwrt_pkg.sv
// hwrt_pkg.sv: shared constants and types of the halt/wake/reset/tick block
// assumes: registers sit at word index * 4 on a 32-bit apb bus
`default_nettype none
package hwrt_pkg;
  // register word indices; byte address is index * 4
  localparam logic [5:0] IDX_TICK_CTRL = 6'h09;
  localparam logic [5:0] IDX_STATUS = 6'h0a;
  localparam logic [5:0] IDX_IRQ_CTRL0 = 6'h0b;
  localparam logic [5:0] IDX_PORT_A = 6'h12;
  // field positions
  localparam int TC_SAVE_BIT = 4;
  localparam int IC0_MASTER_BIT = 0;
  localparam int IC0_TICK_EN_BIT = 3;
  localparam int IC0_TICK_FLAG_BIT = 6;
  localparam int ST_PD_BIT = 4;
  localparam int ST_TO_BIT = 5;
  // reset values
  localparam logic [4:0] TC_RST = 5'h07;
  localparam logic [6:0] IC0_RST = 7'h00;
  localparam logic [7:0] PORT_A_RST = 8'hff;
  localparam logic [7:0] PA_PREV_RST = 8'hff;
  // tick divider: select code 0 divides by 2^8, code 7 by 2^15
  localparam int TICK_DIV_BASE = 8;
  localparam int TICK_DIV_W = 15;
  localparam logic [11:0] TICK_VECTOR = 12'h00c;
  // start-up timer length in system clock periods
  localparam int SST_CYCLES = 1024;
  localparam int SST_W = 10;
  typedef enum logic [1:0] {HWRT_RUN, HWRT_HALT, HWRT_SST} hwrt_state_t;
endpackage : hwrt_pkg
`default_nettype wire

// ### verilog/hwrt_tick_div.sv
// hwrt_tick_div.sv: clock tick divider, 2^8 .. 2^15 of the selected clock
// assumes: fs_pulse is a one-cycle pulse per selected-clock period
`timescale 1ns/100ps
`default_nettype none
module hwrt_tick_div
  import hwrt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic fs_pulse,
  input wire logic [2:0] sel,
  output logic tick_pulse
);
  logic [TICK_DIV_W-1:0] cnt_r;
  logic [TICK_DIV_W-1:0] m;
  logic hit;
  logic tick_r;

  // low-order ones mask for the chosen power of two
  function automatic logic [TICK_DIV_W-1:0] hwrt_mask(input logic [2:0] s);
    hwrt_mask = TICK_DIV_W'((32'd1 << (32'(s) + TICK_DIV_BASE)) - 32'd1);
  endfunction : hwrt_mask

  assign m = hwrt_mask(sel);
  assign hit = fs_pulse && ((cnt_r & m) == m); // [RL1]

  // free-running count; a select change mid-period can shorten or stretch one period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (clr) begin
      cnt_r <= '0; // [RL19]
    end else if (fs_pulse) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= hit && !clr;
    end
  end
  assign tick_pulse = tick_r;

  div_period_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
    tick_pulse |-> $past(fs_pulse) && (($past(cnt_r) & $past(m)) == $past(m)))
    else $error("tick without full divider period");
endmodule : hwrt_tick_div
`default_nettype wire

// ### verilog/hwrt_sst.sv
// hwrt_sst.sv: start-up timer, holds 1024 system clocks after start
// assumes: start may last several cycles, each one restarts the count; timer also runs out of power-up
`timescale 1ns/100ps
`default_nettype none
module hwrt_sst
  import hwrt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [SST_W-1:0] cnt_r;
  logic busy_r;
  logic done_r;

  // busy comes out of reset set so power-up gets the same delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      busy_r <= 1'b1; // [RL17]
      done_r <= 1'b0;
    end else if (start) begin
      cnt_r <= '0; // [RL16]
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end else if (busy_r && cnt_r == SST_W'(SST_CYCLES - 1)) begin
      busy_r <= 1'b0;
      done_r <= 1'b1;
    end else begin
      cnt_r <= busy_r ? cnt_r + 1'b1 : cnt_r;
      done_r <= 1'b0;
    end
  end
  assign busy = busy_r;
  assign done = done_r;

  sst_len_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL17]
    $rose(done) |-> $past(cnt_r) == SST_W'(SST_CYCLES - 1) && !busy)
    else $error("start-up delay length wrong");
endmodule : hwrt_sst
`default_nettype wire

// ### tb/hwrt_pin_model.sv
// hwrt_pin_model.sv: far side of the block, the reset pin and the port a pins
// assumes: the bench raises requests as levels, pins move only after pclk edges
`timescale 1ns/100ps
`default_nettype none
module hwrt_pin_model (
  input wire logic pclk,
  input wire logic rst_req,
  input wire logic [7:0] pin_low,
  output logic ext_reset_pin_n,
  output logic [7:0] port_a_pin
);
  // pins idle high as if pulled up; registered so they never move on the edge
  always @(posedge pclk) begin
    ext_reset_pin_n <= ~rst_req;
    port_a_pin <= ~pin_low;
  end
endmodule : hwrt_pin_model
`default_nettype wire

// ### tb/hwrt_top_test.sv
// hwrt_top_test.sv: self-checking bench of the halt, wake, reset and tick block
// assumes: hwrt_pin_model drives the reset and port a pins, pready is tied high
`timescale 1ns/100ps
`default_nettype none
module hwrt_top_test;
  import hwrt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr, pin_low, port_a_pin, port_a_reg;
  logic [31:0] pwdata, prdata;
  logic halt_instr, wclr_instr, rst_n, wd_ovf, wdt_on_osc, fs_pulse, stack_full, rst_req;
  logic [2:0] ext_irq_flags, ext_irq_en;
  logic sys_osc_en, cpu_hold, chip_reset, warm_reset, watchdog_clear, tick_pulse, tick_call;
  logic resume_next, resume_irq, timeout_flag, powerdown_flag;
  logic [11:0] tick_vector;
  int mismatches = 0, checks = 0, np = 0, cyc = 0, t_last = 0, t_gap = 0, hold_n = 0;
  int n_rn = 0, n_ri = 0, n_wr = 0, n_cr = 0, n_wc = 0, n_tc = 0, n_tp = 0;

  hwrt_top #(.PA_WAKE_EN(8'hff)) i_hwrt_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_instr(halt_instr),
    .watchdog_clear_instr(wclr_instr), .ext_reset_pin_n(rst_n), .watchdog_ovf(wd_ovf),
    .wdt_on_osc(wdt_on_osc), .fs_pulse(fs_pulse), .stack_full(stack_full),
    .ext_irq_flags(ext_irq_flags), .ext_irq_en(ext_irq_en), .port_a_pin(port_a_pin),
    .sys_osc_en(sys_osc_en), .cpu_hold(cpu_hold), .chip_reset(chip_reset),
    .warm_reset(warm_reset), .watchdog_clear(watchdog_clear), .tick_pulse(tick_pulse),
    .tick_call(tick_call), .tick_vector(tick_vector), .resume_next(resume_next),
    .resume_irq(resume_irq), .port_a_reg(port_a_reg), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag));
  hwrt_pin_model i_hwrt_pin_model (.pclk(pclk), .rst_req(rst_req), .pin_low(pin_low),
    .ext_reset_pin_n(rst_n), .port_a_pin(port_a_pin));

  // free-running clock, 25 ns period
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  // pulse tallies, tick spacing and length of each hold, from sampled values
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    n_rn <= n_rn + resume_next;
    n_ri <= n_ri + resume_irq;
    n_wr <= n_wr + warm_reset;
    n_cr <= n_cr + chip_reset;
    n_wc <= n_wc + watchdog_clear;
    n_tc <= n_tc + tick_call;
    n_tp <= n_tp + tick_pulse;
    if (tick_pulse) begin
      t_gap <= cyc - t_last;
      t_last <= cyc;
    end
    if (!presetn || !sys_osc_en) hold_n <= 0;
    else if (cpu_hold) hold_n <= hold_n + 1;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one apb transfer; waits for pready, a stall is left to the watchdog
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask : rdchk

  // one-cycle core pulse: 0 halt, 1 watchdog clear, other watchdog overflow
  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: halt_instr <= 1'b1;
      1: wclr_instr <= 1'b1;
      default: wd_ovf <= 1'b1;
    endcase
    @(posedge pclk);
    halt_instr <= 1'b0;
    wclr_instr <= 1'b0;
    wd_ovf <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  // bounded wait for the core to be let go
  task automatic wait_run();
    int n;
    n = 0;
    while (cpu_hold !== 1'b0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) mismatches++;
    repeat (2) @(posedge pclk);
  endtask : wait_run

  // power-up hold, reset values, unmapped and read-only places, save bit
  task automatic t_reset();
    logic [31:0] r;
    wait_run();
    check(hold_n >= 1024 && hold_n <= 1026, 1'b1);
    rdchk(8'h24, 32'h07);
    rdchk(8'h28, 32'h00);
    rdchk(8'h2c, 32'h00);
    rdchk(8'h48, 32'hff);
    apb(1'b0, 8'h10, 32'h0, r);
    check({r[30:0], perr}, 32'h01);
    wr(8'h28, 32'h30);
    rdchk(8'h28, 32'h00);
    wr(8'h24, 32'h17);
    rdchk(8'h24, 32'h17);
  endtask : t_reset

  // tick period for select codes 0 to 6, then flag, call and vector
  task automatic t_tick();
    int s, k;
    fs_pulse <= 1'b1;
    for (s = 0; s < 7; s++) begin
      wr(8'h24, s);
      k = n_tp + 2;
      while (n_tp < k && cyc < 80000) @(posedge pclk);
      @(posedge pclk);
      check(t_gap, 32'h1 << (8 + s));
    end
    fs_pulse <= 1'b0;
    rdchk(8'h2c, 32'h40);
    k = n_tc;
    wr(8'h2c, 32'h49);
    repeat (3) @(posedge pclk);
    check(n_tc, k + 1);
    check(tick_vector, 12'h00c);
    rdchk(8'h2c, 32'h09);
  endtask : t_tick

  // watchdog overflow while running is a full chip reset
  task automatic t_wdt_run();
    int a;
    wr(8'h24, 32'h1d);
    wr(8'h48, 32'h5a);
    a = n_cr;
    pulse(2);
    wait_run();
    check(n_cr, a + 1);
    rdchk(8'h28, 32'h20);
    rdchk(8'h24, 32'h07);
    rdchk(8'h2c, 32'h00);
    rdchk(8'h48, 32'hff);
  endtask : t_wdt_run

  // halt, then a falling port pin wakes to the next instruction
  task automatic t_halt_port();
    int k;
    wdt_on_osc <= 1'b1;
    k = n_wc;
    pulse(0);
    check(sys_osc_en, 1'b0);
    check(n_wc, k + 1);
    rdchk(8'h28, 32'h10);
    check({timeout_flag, powerdown_flag}, 2'b01);
    check(port_a_reg, 8'hff);
    k = n_rn;
    pin_low <= 8'h01;
    wait_run();
    pin_low <= 8'h00;
    check(n_rn, k + 1);
    check(hold_n >= 1024 && hold_n <= 1027, 1'b1);
    np = hold_n;
  endtask : t_halt_port

  // interrupt wake; vectors only when enabled and the stack has room
  task automatic t_halt_irq(input logic en, input logic full, input int exp_irq);
    int k, a, b;
    wr(8'h2c, 32'h01);
    ext_irq_en <= {2'b00, en};
    stack_full <= full;
    wdt_on_osc <= 1'b0;
    k = n_wc;
    a = n_ri;
    b = n_rn;
    pulse(0);
    ext_irq_flags <= 3'b001;
    wait_run();
    ext_irq_flags <= 3'b000;
    check(n_wc, k);
    check(n_ri, a + exp_irq);
    check(n_rn, b + 1 - exp_irq);
    check(hold_n, np + exp_irq);
  endtask : t_halt_irq

  // stale flag cannot wake; watchdog overflow in halt is a warm reset
  task automatic t_warm();
    int k, a;
    wr(8'h24, 32'h15);
    stack_full <= 1'b0;
    ext_irq_flags <= 3'b001;
    pulse(0);
    repeat (40) @(posedge pclk);
    check(sys_osc_en, 1'b0);
    k = n_wr;
    a = n_cr;
    pulse(2);
    wait_run();
    ext_irq_flags <= 3'b000;
    check(n_wr, k + 1);
    check(n_cr, a);
    rdchk(8'h28, 32'h30);
    check({timeout_flag, powerdown_flag}, 2'b11);
    rdchk(8'h24, 32'h15);
  endtask : t_warm

  // reset pin in run or in halt, flags tell which
  task automatic t_pin(input logic in_halt, input logic [31:0] exp);
    wr(8'h48, 32'h5a);
    if (in_halt) pulse(0);
    rst_req <= 1'b1;
    repeat (3) @(posedge pclk);
    rst_req <= 1'b0;
    wait_run();
    rdchk(8'h28, exp);
    check({timeout_flag, powerdown_flag}, exp[5:4]);
    rdchk(8'h48, 32'hff);
    rdchk(8'h24, 32'h07);
  endtask : t_pin

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // main sequence; the flag history of each step feeds the next
  initial begin
    {presetn, psel, penable, pwrite, halt_instr, wclr_instr, wd_ovf} = '0;
    {wdt_on_osc, fs_pulse, stack_full, rst_req, perr} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin_low = 8'h00;
    ext_irq_flags = 3'b000;
    ext_irq_en = 3'b000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tick();
    t_wdt_run();
    t_halt_port();
    t_halt_irq(1'b1, 1'b0, 1);
    t_halt_irq(1'b0, 1'b0, 0);
    t_halt_irq(1'b1, 1'b1, 0);
    t_warm();
    pulse(1);
    rdchk(8'h28, 32'h20);
    t_pin(1'b0, 32'h20);
    t_pin(1'b1, 32'h10);
    final_report();
  end

  // hang guard, well above the expected run length
  initial begin
    repeat (90000) @(posedge pclk);
    mismatches++;
    final_report();
  end
endmodule : hwrt_top_test
`default_nettype wire
